//--- common/osc_defines.svh
// constants for the oscillator start-up control block
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH
`define OSC_ADDR_CW1 12'h000
`define OSC_ADDR_CW2 12'h004
`define OSC_ADDR_OSCCTL 12'h008
`define OSC_ADDR_RSTCTL 12'h00c
`define OSC_ADDR_STATUS 12'h010
`define OSC_CW1_WDT_FUSE 7
`define OSC_CW2_DUAL_SPEED 15
`define OSC_CW2_SEL_LO 8
`define OSC_CW2_SEL_HI 10
`define OSC_OCTL_NEXT_LO 8
`define OSC_OCTL_NEXT_HI 10
`define OSC_OCTL_CUR_LO 12
`define OSC_OCTL_CUR_HI 14
`define OSC_OCTL_SWITCH 0
`define OSC_OCTL_SLEEP_KEEP 2
`define OSC_RCTL_WDT_SOFT 5
`define OSC_CW1_RESET 32'h0000_0080
`define OSC_CW2_RESET 32'h0000_8000
`define OSC_SWITCH_CYCLES 8'h08
`endif

//--- common/osc_pkg.sv
// types for the oscillator start-up control block
package osc_pkg;
   typedef enum logic [2:0] {
      OSC_FRC = 3'b000, OSC_FRC_PLL = 3'b001, OSC_PRI = 3'b010, OSC_PRI_PLL = 3'b011,
      OSC_SEC = 3'b100, OSC_LOW_POWER_RC_OSC = 3'b101, OSC_RSV = 3'b110, OSC_FRC_DIV = 3'b111
   } osc_sel_t;
   typedef enum logic [1:0] {
      OSC_SW_IDLE = 2'b00, OSC_SW_WAIT = 2'b01, OSC_SW_DONE = 2'b10
   } osc_sw_state_t;
   typedef struct packed {
      logic primary_on;
      logic low_power_rc_osc_on;
      logic pll_on;
      logic watchdog_on;
   } osc_en_t;
endpackage

//--- hdl/osc_startup_ctl.sv
// oscillator selection and start-up control with apb registers
// Behaviour
// - dual-speed start-up never runs, whatever its configuration enable says.
// - the keep-in-sleep bit has no effect while the current oscillator is primary with PLL.
// - in primary PLL modes, sleep turns the primary oscillator off regardless of keep-in-sleep.
// - in primary modes without PLL, keep-in-sleep keeps the primary oscillator running in sleep.
// - after a brown-out the low-power rc may not restart, stopping PLL and watchdog.
`include "osc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module osc_startup_ctl (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // power state
   input wire logic sleep_req,
   input wire logic brownout_reset,
   // clock enables and oscillator status
   output osc_pkg::osc_en_t osc_en,
   output logic [2:0] current_osc_status,
   output logic dual_speed_active
);
   logic [31:0] cw1_q, cw2_q;
   logic [2:0] next_osc_select_q, cur_q;
   logic sleep_keep_q, sw_req_q, wdt_soft_q, low_power_rc_osc_q, init_q;
   logic [7:0] sw_cnt_q;
   osc_pkg::osc_sw_state_t sw_state_q;
   logic slp_s1_q, slp_s2_q, slp_s3_q, slp_q;
   logic bor_s1_q, bor_s2_q, bor_s3_q, bor_q;
   logic wr, rd;
   osc_pkg::osc_en_t en_d;
   logic pll_mode, pri_mode;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;

   // three-stage input filters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {slp_s1_q, slp_s2_q, slp_s3_q, slp_q} <= 4'h0;
         {bor_s1_q, bor_s2_q, bor_s3_q, bor_q} <= 4'h0;
      end else begin
         slp_s1_q <= sleep_req;
         slp_s2_q <= slp_s1_q;
         slp_s3_q <= slp_s2_q;
         if (slp_s2_q == slp_s3_q) slp_q <= slp_s3_q;
         bor_s1_q <= brownout_reset;
         bor_s2_q <= bor_s1_q;
         bor_s3_q <= bor_s2_q;
         if (bor_s2_q == bor_s3_q) bor_q <= bor_s3_q;
      end
   end

   // configuration words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cw1_q <= `OSC_CW1_RESET;
         cw2_q <= `OSC_CW2_RESET;
      end else if (wr && paddr == `OSC_ADDR_CW1) begin
         cw1_q <= pwdata;
      end else if (wr && paddr == `OSC_ADDR_CW2) begin
         cw2_q <= pwdata;
      end
   end

   // control register and soft watchdog enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         next_osc_select_q <= 3'h0;
         sleep_keep_q <= 1'b0;
         wdt_soft_q <= 1'b0;
      end else begin
         if (wr && paddr == `OSC_ADDR_OSCCTL) begin
            next_osc_select_q <= pwdata[`OSC_OCTL_NEXT_HI:`OSC_OCTL_NEXT_LO];
            sleep_keep_q <= pwdata[`OSC_OCTL_SLEEP_KEEP];
         end
         if (wr && paddr == `OSC_ADDR_RSTCTL) wdt_soft_q <= pwdata[`OSC_RCTL_WDT_SOFT];
      end
   end

   // clock switch sequencer; switch requests are accepted in idle only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_state_q <= osc_pkg::OSC_SW_IDLE;
         sw_cnt_q <= 8'h00;
         cur_q <= 3'h0;
         init_q <= 1'b0;
         sw_req_q <= 1'b0;
      end else begin
         if (!init_q) begin
            init_q <= 1'b1;
            cur_q <= cw2_q[`OSC_CW2_SEL_HI:`OSC_CW2_SEL_LO];
         end
         case (sw_state_q)
            osc_pkg::OSC_SW_IDLE: begin
               if (wr && paddr == `OSC_ADDR_OSCCTL && pwdata[`OSC_OCTL_SWITCH]) begin
                  sw_state_q <= osc_pkg::OSC_SW_WAIT;
                  sw_cnt_q <= `OSC_SWITCH_CYCLES;
                  sw_req_q <= 1'b1;
               end
            end
            osc_pkg::OSC_SW_WAIT: begin
               if (sw_cnt_q == 8'h00) sw_state_q <= osc_pkg::OSC_SW_DONE;
               else sw_cnt_q <= sw_cnt_q - 8'h01;
            end
            osc_pkg::OSC_SW_DONE: begin
               cur_q <= next_osc_select_q;
               sw_req_q <= 1'b0;
               sw_state_q <= osc_pkg::OSC_SW_IDLE;
            end
            default: sw_state_q <= osc_pkg::OSC_SW_IDLE;
         endcase
      end
   end

   // low-power rc: a brown-out may leave it stopped until software restarts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_power_rc_osc_q <= 1'b1;
      end else if (bor_q) begin
         low_power_rc_osc_q <= 1'b0;
      end else if (wr && paddr == `OSC_ADDR_STATUS && pwdata[1]) begin
         low_power_rc_osc_q <= 1'b1;
      end
   end

   assign pll_mode = (cur_q == osc_pkg::OSC_PRI_PLL);
   assign pri_mode = (cur_q == osc_pkg::OSC_PRI);

   always_comb begin
      en_d.low_power_rc_osc_on = low_power_rc_osc_q;
      en_d.pll_on = low_power_rc_osc_q && (pll_mode || cur_q == osc_pkg::OSC_FRC_PLL) && !slp_q;
      en_d.watchdog_on = low_power_rc_osc_q && (cw1_q[`OSC_CW1_WDT_FUSE] || wdt_soft_q);
      if (pll_mode) en_d.primary_on = !slp_q;
      else if (pri_mode) en_d.primary_on = !slp_q || sleep_keep_q;
      else en_d.primary_on = 1'b0;
   end

   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_en <= '0;
         current_osc_status <= 3'h0;
         dual_speed_active <= 1'b0;
      end else begin
         osc_en <= en_d;
         current_osc_status <= cur_q;
         dual_speed_active <= 1'b0;
      end
   end

   // apb read data, one wait-free access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable) begin
            case (paddr)
               `OSC_ADDR_CW1: prdata <= cw1_q;
               `OSC_ADDR_CW2: prdata <= cw2_q;
               `OSC_ADDR_OSCCTL: prdata <= {17'h0, cur_q, 1'b0, next_osc_select_q, 5'h0,
                                            sleep_keep_q, 1'b0, sw_req_q};
               `OSC_ADDR_RSTCTL: prdata <= {26'h0, wdt_soft_q, 5'h0};
               `OSC_ADDR_STATUS: prdata <= {30'h0, low_power_rc_osc_q, 1'b0};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   a_pll_sleep_off: assert property (@(posedge pclk) disable iff (!presetn)
      (pll_mode && slp_q) |=> !osc_en.primary_on) else $error("primary on in pll sleep");
   a_keep_in_sleep: assert property (@(posedge pclk) disable iff (!presetn)
      (pri_mode && slp_q && sleep_keep_q) |=> osc_en.primary_on) else $error("primary lost");
   a_pll_keep_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (pll_mode && slp_q && sleep_keep_q) |=> !osc_en.primary_on) else $error("keep bit acted");
   a_no_dual_speed: assert property (@(posedge pclk) disable iff (!presetn)
      !dual_speed_active) else $error("dual speed active");
   a_switch_done: assert property (@(posedge pclk) disable iff (!presetn)
      (sw_state_q == osc_pkg::OSC_SW_DONE) |=> (cur_q == $past(next_osc_select_q))) else $error("status stale");
   // a brown-out first stops the rc, then the watchdog enable falls a cycle later
   sequence s_low_power_rc_osc_drop;
      !low_power_rc_osc_q;
   endsequence
   sequence s_wdt_drop;
      !osc_en.watchdog_on;
   endsequence
   a_bor_low_power_rc_osc_off: assert property (@(posedge pclk) disable iff (!presetn)
      bor_q |=> s_low_power_rc_osc_drop ##1 s_wdt_drop) else $error("low_power_rc_osc kept after brownout");
   a_low_power_rc_osc_pll_off: assert property (@(posedge pclk) disable iff (!presetn)
      !low_power_rc_osc_q |=> !osc_en.pll_on) else $error("pll on without rc");
   a_status_port: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (current_osc_status == $past(cur_q))) else $error("status port stale");
   // the bus answer stands for one cycle only
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("ready held too long");
   a_wdt_enable: assert property (@(posedge pclk) disable iff (!presetn)
      (low_power_rc_osc_q && wdt_soft_q) |=> osc_en.watchdog_on) else $error("watchdog not enabled");
   a_switch_bound: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sw_req_q) |-> ##[1:11] !sw_req_q) else $error("switch too long");
endmodule // osc_startup_ctl
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the oscillator start-up control block
`include "osc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, sleep_req, brownout_reset;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, dual_speed_active;
   logic [2:0] current_osc_status;
   osc_pkg::osc_en_t osc_en;
   int n_fail = 0;
   int check_count = 0;
   osc_startup_ctl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .brownout_reset(brownout_reset),
      .osc_en(osc_en), .current_osc_status(current_osc_status),
      .dual_speed_active(dual_speed_active));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; read data and error are taken at the edge where pready is seen
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      logic ok;
      n = 0;
      ok = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      while (!ok && n < 20) begin
         @(posedge pclk);
         n++;
         ok = (pready === 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (!ok) begin
         n_fail++;
         give_verdict();
      end
   endtask
   task automatic wait_cur(input logic [2:0] exp);
      int n;
      for (n = 0; n < 40 && current_osc_status !== exp; n++) @(posedge pclk);
      chk(32'(current_osc_status), 32'(exp));
      if (n >= 40) begin
         give_verdict();
      end
   endtask
   task automatic t_reset();
      apb(1'b0, `OSC_ADDR_CW1, 32'h0000_0000);
      chk(rd, `OSC_CW1_RESET);
      apb(1'b0, `OSC_ADDR_CW2, 32'h0000_0000);
      chk(rd, `OSC_CW2_RESET);
      chk(32'(current_osc_status), 32'h0000_0000);
      chk(32'(dual_speed_active), 32'h0000_0000);
      apb(1'b1, `OSC_ADDR_CW2, 32'h0000_0000);
      apb(1'b0, `OSC_ADDR_CW2, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk({rd[30:0], err}, 32'h0000_0001);
      $display("t_reset done");
   endtask
   task automatic t_switch();
      repeat (400) @(posedge pclk);
      apb(1'b1, `OSC_ADDR_OSCCTL, 32'h0000_0305);
      wait_cur(3'b011);
      repeat (2) @(posedge pclk);
      chk(32'(osc_en.pll_on), 32'h0000_0001);
      apb(1'b0, `OSC_ADDR_OSCCTL, 32'h0000_0000);
      chk(rd, 32'h0000_3304);
      sleep_req <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(32'(osc_en.primary_on), 32'h0000_0000);
      chk(32'(osc_en.pll_on), 32'h0000_0000);
      sleep_req <= 1'b0;
      apb(1'b1, `OSC_ADDR_OSCCTL, 32'h0000_0205);
      wait_cur(3'b010);
      sleep_req <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(32'(osc_en.primary_on), 32'h0000_0001);
      sleep_req <= 1'b0;
      $display("t_switch done");
   endtask
   task automatic t_wdt();
      apb(1'b1, `OSC_ADDR_CW1, 32'h0000_0000);
      repeat (4) @(posedge pclk);
      chk(32'(osc_en.watchdog_on), 32'h0000_0000);
      repeat (400) @(posedge pclk);
      apb(1'b1, `OSC_ADDR_RSTCTL, 32'h0000_0020);
      repeat (4) @(posedge pclk);
      chk(32'(osc_en.watchdog_on), 32'h0000_0001);
      $display("t_wdt done");
   endtask
   task automatic t_brown();
      brownout_reset <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(32'(osc_en.low_power_rc_osc_on), 32'h0000_0000);
      chk(32'(osc_en.watchdog_on), 32'h0000_0000);
      brownout_reset <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1'b0, `OSC_ADDR_STATUS, 32'h0000_0000);
      chk(32'(rd[1]), 32'h0000_0000);
      apb(1'b1, `OSC_ADDR_STATUS, 32'h0000_0002);
      repeat (4) @(posedge pclk);
      chk(32'(osc_en.low_power_rc_osc_on), 32'h0000_0001);
      $display("t_brown done");
   endtask
   initial begin
      {presetn, psel, penable, pwrite, sleep_req, brownout_reset} = 6'b00_0000;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_switch();
      t_wdt();
      t_brown();
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
